// ---- hw/pips_cfg.svh ----
// offsets, field positions, reset values and frame counts of the interrupt/power-save block
`ifndef PIPS_CFG_SVH
`define PIPS_CFG_SVH
// management register offsets
`define PIPS_REG_BASIC 5'h00
`define PIPS_REG_PSC 5'h11
`define PIPS_REG_ISA 5'h12
`define PIPS_REG_ISB 5'h13
// basic_control fields
`define PIPS_BC_SWRST 15
`define PIPS_BC_PWRDN 11
// power_save_and_int_control fields
`define PIPS_PSC_PS_EN 14
`define PIPS_PSC_SEL_HI 13
`define PIPS_PSC_SEL_LO 12
`define PIPS_PSC_INT_POL 2
`define PIPS_PSC_INT_EN 1
`define PIPS_PSC_INT_OE 0
// power-save select codes
`define PIPS_SEL_PWRDN 2'h1
`define PIPS_SEL_LP_ACT 2'h2
`define PIPS_SEL_LP_PAS 2'h3
// interrupt register layout: enables low byte, status high byte
`define PIPS_EN_HI 7
`define PIPS_EN_LO 0
`define PIPS_ST_HI 15
`define PIPS_ST_LO 8
// reset values
`define PIPS_BC_RST_VAL 16'h0000
`define PIPS_PSC_RST_VAL 16'h0000
`define PIPS_IEN_RST_VAL 8'h00
`define PIPS_IST_RST_VAL 8'h00
// management frame counts and opcodes
`define PIPS_PRE_LEN 6'h20
`define PIPS_HDR_LAST 4'hB
`define PIPS_DATA_LAST 4'hF
`define PIPS_OP_WR 2'h1
`define PIPS_OP_RD 2'h2
`endif

// ---- hw/pips_ctrl.sv ----
// interrupt signalling and power-save control, with its management slave
// Function
// - all interrupt sources disabled after reset
// - per-source enable bits in registers 0x12, 0x13
// - enabled event drives shared pin active asynchronously (low, or high when bit 2 set)
// - status registers show every pending interrupt
// - reading a status register clears its own pending bits, except events live in that read cycle
// - power-down by pin low or control bit 11
// - power-down keeps management access, interrupt latching and pin drive alive
// - bit 14 gates the power-save select field
// - select 01 down, 10 active-save, 11 passive-save
// - clearing select restores prior operating state
// - pin is power-down input unless bit 0 set
// - control register holds interrupt enable, polarity
`timescale 1ns/1ns
`default_nettype none
`include "pips_cfg.svh"
module pips_ctrl #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // management pins
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  // shared interrupt / power-down pin
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe,
  // interrupt event levels from the transceiver core
  input wire logic [7:0] int_evt_a,
  input wire logic [7:0] int_evt_b,
  // power state to the core
  output var pips_pkg::pips_pmode_t pwr_mode,
  output logic core_pwr_dn
);
  import pips_pkg::*;

  pips_ctrl_st_t s, n;
  pips_req_t req;
  logic [7:0] set_a;
  logic [7:0] set_b;
  logic rd_a;
  logic rd_b;
  logic live;
  logic pend;
  logic int_act;
  logic pin_pd;
  logic [1:0] sel;

  //////////////////////////////////////////////////////////////////////////////
  // management slave
  pips_smi #(
    .PHY_ADDR(PHY_ADDR)
  ) u_smi (
    .sys_clk(sys_clk),
    .rst(rst),
    .mdc(mdc),
    .mdio_i(mdio_i),
    .mdio_o(mdio_o),
    .mdio_oe(mdio_oe),
    .req(req),
    .rd_data(s.rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // interrupt sources and pin drive
  assign set_a = int_evt_a & s.en_a;
  assign set_b = int_evt_b & s.en_b;
  assign rd_a = req.rd && req.addr == `PIPS_REG_ISA;
  assign rd_b = req.rd && req.addr == `PIPS_REG_ISB;
  assign live = |set_a || |set_b;
  assign pend = |s.st_a || |s.st_b;
  // live term is combinational so the pin moves without waiting for a clock
  assign int_act = s.psc[`PIPS_PSC_INT_EN] && (live || pend);
  assign pin_oe = s.psc[`PIPS_PSC_INT_OE];
  assign pin_o = s.psc[`PIPS_PSC_INT_POL] ? int_act : !int_act;

  // power-down request from the pin, only while it is an input
  assign pin_pd = !s.psc[`PIPS_PSC_INT_OE] && !s.pin_sync[1];
  // select field is ignored unless the enable bit is set
  assign sel = s.psc[`PIPS_PSC_PS_EN] ?
               s.psc[`PIPS_PSC_SEL_HI:`PIPS_PSC_SEL_LO] : 2'h0;

  //////////////////////////////////////////////////////////////////////////////
  // next state: registers, sticky status, power mode
  always_comb begin
    n = s;
    n.pin_sync = {s.pin_sync[0], pin_i};
    // a new event in the read cycle survives the clear
    n.st_a = (s.st_a & ~{8{rd_a}}) | set_a;
    n.st_b = (s.st_b & ~{8{rd_b}}) | set_b;
    if (req.rd) begin
      case (req.addr)
        `PIPS_REG_BASIC: n.rdata = s.basic;
        `PIPS_REG_PSC: n.rdata = s.psc;
        `PIPS_REG_ISA: n.rdata = {s.st_a | set_a, s.en_a};
        `PIPS_REG_ISB: n.rdata = {s.st_b | set_b, s.en_b};
        default: n.rdata = 16'h0000;
      endcase
    end
    // writes stay live in every power state
    if (req.wr) begin
      case (req.addr)
        `PIPS_REG_BASIC: begin
          // software reset only returns this register to default
          if (req.wdata[`PIPS_BC_SWRST]) begin
            n.basic = `PIPS_BC_RST_VAL;
          end else begin
            n.basic = req.wdata;
          end
        end
        `PIPS_REG_PSC: n.psc = req.wdata;
        `PIPS_REG_ISA: n.en_a = req.wdata[`PIPS_EN_HI:`PIPS_EN_LO];
        `PIPS_REG_ISB: n.en_b = req.wdata[`PIPS_EN_HI:`PIPS_EN_LO];
        default: n.basic = s.basic;
      endcase
    end
    // power-down has priority over the energy-saving modes
    if (s.basic[`PIPS_BC_PWRDN] || pin_pd || sel == `PIPS_SEL_PWRDN) begin
      n.mode = PM_PWRDN;
    end else if (sel == `PIPS_SEL_LP_ACT) begin
      n.mode = PM_LP_ACT;
    end else if (sel == `PIPS_SEL_LP_PAS) begin
      n.mode = PM_LP_PAS;
    end else begin
      n.mode = PM_ACTIVE;
    end
  end

  // state register; enables clear on reset so no source reaches the pin
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s.basic <= `PIPS_BC_RST_VAL;
      s.psc <= `PIPS_PSC_RST_VAL;
      s.en_a <= `PIPS_IEN_RST_VAL;
      s.en_b <= `PIPS_IEN_RST_VAL;
      s.st_a <= `PIPS_IST_RST_VAL;
      s.st_b <= `PIPS_IST_RST_VAL;
      s.pin_sync <= 2'h3;
      s.mode <= PM_ACTIVE;
      s.rdata <= 16'h0000;
    end else begin
      s <= n;
    end
  end

  // core keeps its state while gated, so it resumes where it stopped
  assign pwr_mode = s.mode;
  assign core_pwr_dn = s.mode == PM_PWRDN;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_sel_pd;
    s.psc[`PIPS_PSC_PS_EN] && s.psc[`PIPS_PSC_SEL_HI:`PIPS_PSC_SEL_LO] == `PIPS_SEL_PWRDN;
  endsequence
  sequence s_sel_off;
    s.psc[`PIPS_PSC_SEL_HI:`PIPS_PSC_SEL_LO] == 2'h0 && !s.basic[`PIPS_BC_PWRDN] && !pin_pd;
  endsequence
  // status read of group a while group b is empty and no enabled event is live
  sequence s_clear_read;
    rd_a && s.st_b == 8'h00 && !live;
  endsequence

  a_src_disabled: assert property (
    (s.en_a == 8'h00 && s.st_a == 8'h00) |=> s.st_a == 8'h00)
    else $error("status set for a disabled source");
  a_enable_sets: assert property (
    |(int_evt_b & s.en_b) |=> s.st_b != 8'h00)
    else $error("enabled event not latched");
  a_pin_async: assert property (
    (s.psc[`PIPS_PSC_INT_OE] && s.psc[`PIPS_PSC_INT_EN] && !s.psc[`PIPS_PSC_INT_POL]
     && live) |-> (pin_oe && !pin_o))
    else $error("interrupt pin not low with an enabled event");
  a_status_shows: assert property (
    (rd_a && s.st_a != 8'h00) |=> s.rdata[`PIPS_ST_HI:`PIPS_ST_LO] == $past(s.st_a))
    else $error("status read lost a pending bit");
  a_read_clears: assert property (
    (rd_b && int_evt_b == 8'h00) |=> s.st_b == 8'h00)
    else $error("status read did not clear pending bits");
  a_bit_pwrdn: assert property (
    s.basic[`PIPS_BC_PWRDN] |=> pwr_mode == PM_PWRDN)
    else $error("control bit did not power down");
  a_pin_pwrdn: assert property (
    (!s.psc[`PIPS_PSC_INT_OE] && !s.pin_sync[1]) |=> core_pwr_dn)
    else $error("pin low did not power down");
  a_smi_alive: assert property (
    (core_pwr_dn && req.wr && req.addr == `PIPS_REG_ISA)
    |=> s.en_a == $past(req.wdata[`PIPS_EN_HI:`PIPS_EN_LO]))
    else $error("register write lost during power-down");
  a_sel_gated: assert property (
    (!s.psc[`PIPS_PSC_PS_EN] && !s.basic[`PIPS_BC_PWRDN] && !pin_pd) |=> pwr_mode == PM_ACTIVE)
    else $error("select honoured without enable bit");
  a_lp_active: assert property (
    (sel == `PIPS_SEL_LP_ACT && !s.basic[`PIPS_BC_PWRDN] && !pin_pd) |=> pwr_mode == PM_LP_ACT)
    else $error("active energy-saving mode not entered");
  a_sel_resume: assert property (
    s_sel_pd ##1 s_sel_off |=> pwr_mode == PM_ACTIVE)
    else $error("no power-up after select cleared");
  a_pin_input: assert property (
    !s.psc[`PIPS_PSC_INT_OE] |-> !pin_oe)
    else $error("pin driven while configured as input");
  a_int_master: assert property (
    (!s.psc[`PIPS_PSC_INT_EN] && pin_oe) |-> pin_o == !s.psc[`PIPS_PSC_INT_POL])
    else $error("pin asserted with interrupts masked");
  // a read that fails to clear leaves pending set and keeps the pin active
  a_pin_release: assert property (
    s_clear_read ##1 !live |-> pin_o == !s.psc[`PIPS_PSC_INT_POL])
    else $error("pin not released after clear");
endmodule : pips_ctrl
`default_nettype wire

// ---- hw/pips_pkg.sv ----
// types shared by the interrupt/power-save controller and its management slave
package pips_pkg;
  // power state presented to the rest of the transceiver
  typedef enum logic [1:0] {PM_ACTIVE, PM_PWRDN, PM_LP_ACT, PM_LP_PAS} pips_pmode_t;
  // management frame phases
  typedef enum logic [2:0] {SP_PRE, SP_ST, SP_HDR, SP_TA, SP_DATA} pips_smi_ph_t;
  // one register access from the management slave
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } pips_req_t;
  // controller state
  typedef struct packed {
    logic [15:0] basic;
    logic [15:0] psc;
    logic [7:0] en_a;
    logic [7:0] en_b;
    logic [7:0] st_a;
    logic [7:0] st_b;
    logic [1:0] pin_sync;
    pips_pmode_t mode;
    logic [15:0] rdata;
  } pips_ctrl_st_t;
  // management slave state
  typedef struct packed {
    logic [2:0] mdc_s;
    logic [1:0] mdio_s;
    pips_smi_ph_t ph;
    logic [5:0] ones;
    logic [3:0] cnt;
    logic [11:0] hdr;
    logic [15:0] sh;
    logic is_rd;
    logic oe;
    logic o;
    pips_req_t req;
  } pips_smi_st_t;
endpackage : pips_pkg

// ---- hw/pips_smi.sv ----
// serial management interface slave: frame decode, register read and write strobes
`timescale 1ns/1ns
`default_nettype none
`include "pips_cfg.svh"
module pips_smi #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // management pins
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  // register side
  output var pips_pkg::pips_req_t req,
  input wire logic [15:0] rd_data
);
  import pips_pkg::*;

  pips_smi_st_t s, n;
  logic edge_r;
  logic bit_v;
  logic [11:0] full;

  assign edge_r = s.mdc_s[1] && !s.mdc_s[2]; // rising mdc, synchronised
  assign bit_v = s.mdio_s[1];
  assign full = {s.hdr[10:0], bit_v};

  //////////////////////////////////////////////////////////////////////////////
  // frame state machine, advanced once per mdc rising edge
  always_comb begin
    n = s;
    n.mdc_s = {s.mdc_s[1:0], mdc};
    n.mdio_s = {s.mdio_s[0], mdio_i};
    n.req.rd = 1'b0; // strobes last one cycle
    n.req.wr = 1'b0;
    if (edge_r) begin
      unique case (s.ph)
        SP_PRE: begin
          if (bit_v) begin
            n.ones = (s.ones == `PIPS_PRE_LEN) ? s.ones : s.ones + 6'h01;
          end else if (s.ones == `PIPS_PRE_LEN) begin
            n.ph = SP_ST;
          end else begin
            n.ones = 6'h00;
          end
        end
        SP_ST: begin
          n.ones = 6'h00;
          n.cnt = 4'h0;
          n.ph = bit_v ? SP_HDR : SP_PRE;
        end
        SP_HDR: begin
          n.hdr = full;
          n.cnt = s.cnt + 4'h1;
          if (s.cnt == `PIPS_HDR_LAST) begin
            n.cnt = 4'h0;
            n.req.addr = full[4:0];
            n.is_rd = (full[11:10] == `PIPS_OP_RD);
            // frames for another address or opcode are dropped
            if (full[9:5] == PHY_ADDR && full[11:10] == `PIPS_OP_RD) begin
              n.req.rd = 1'b1;
              n.ph = SP_TA;
            end else if (full[9:5] == PHY_ADDR && full[11:10] == `PIPS_OP_WR) begin
              n.ph = SP_TA;
            end else begin
              n.ph = SP_PRE;
            end
          end
        end
        SP_TA: begin
          n.cnt = s.cnt + 4'h1;
          if (s.cnt == 4'h0) begin
            n.oe = s.is_rd;
            n.o = 1'b0;
          end else begin
            n.cnt = 4'h0;
            n.o = rd_data[15];
            n.sh = {rd_data[14:0], 1'b0};
            n.ph = SP_DATA;
          end
        end
        SP_DATA: begin
          n.cnt = s.cnt + 4'h1;
          if (s.is_rd) begin
            n.o = s.sh[15];
            n.sh = {s.sh[14:0], 1'b0};
          end else begin
            n.sh = {s.sh[14:0], bit_v};
          end
          if (s.cnt == `PIPS_DATA_LAST) begin
            n.oe = 1'b0;
            n.o = 1'b0;
            n.cnt = 4'h0;
            n.ph = SP_PRE;
            n.req.wr = !s.is_rd;
            n.req.wdata = {s.sh[14:0], bit_v};
          end
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign mdio_o = s.o;
  assign mdio_oe = s.oe;
  assign req = s.req;
endmodule : pips_smi
`default_nettype wire

// ---- sim/phy_interrupt_power_save_ctrl_tb.sv ----
// self-checking bench of the interrupt and power-save controller
`timescale 1ns/1ns
`default_nettype none
`include "pips_cfg.svh"
module phy_interrupt_power_save_ctrl_tb;
  import pips_pkg::*;
  localparam logic [4:0] ADR = 5'h03;
  logic sys_clk, rst, mdc, h_oe, h_o, mdio_o, mdio_oe, pin_o, pin_oe, core_pwr_dn, pin_ext_low;
  logic [7:0] int_evt_a, int_evt_b;
  logic [15:0] q;
  pips_pmode_t pwr_mode;
  int num_errors = 0;
  int checks_done = 0;
  // both wires have pull-ups: released means high
  wire logic mdio_line = mdio_oe ? mdio_o : (h_oe ? h_o : 1'b1);
  // the external party can pull the line low even while the block drives it high
  wire logic pin_i = (pin_oe ? pin_o : 1'b1) & !pin_ext_low;
  pips_ctrl #(.PHY_ADDR(ADR)) pips_ctrl_i (.sys_clk(sys_clk), .rst(rst), .mdc(mdc),
    .mdio_i(mdio_line), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe(pin_oe), .int_evt_a(int_evt_a), .int_evt_b(int_evt_b), .pwr_mode(pwr_mode),
    .core_pwr_dn(core_pwr_dn));
  pips_host #(.PHY_ADDR(ADR)) pips_host_i (.sys_clk(sys_clk), .mdc(mdc), .h_oe(h_oe),
    .h_o(h_o), .mdio_line(mdio_line));
  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  ////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    pips_host_i.frame(1'b0, a, d, q);
    @(negedge sys_clk);
  endtask : wr
  task automatic rd(input logic [4:0] a);
    pips_host_i.frame(1'b1, a, 16'h0000, q);
    @(negedge sys_clk);
  endtask : rd
  task automatic results;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  ////////////////////
  // reset values, disabled sources, unmapped address
  task automatic t_reset;
    logic [4:0] regs [4];
    regs = '{`PIPS_REG_BASIC, `PIPS_REG_PSC, `PIPS_REG_ISA, `PIPS_REG_ISB};
    check("pin_oe", 16'(pin_oe), 16'h0000);
    check("pwr_mode", 16'(pwr_mode), 16'(PM_ACTIVE));
    foreach (regs[i]) begin
      rd(regs[i]);
      check("reset value", q, 16'h0000);
    end
    @(posedge sys_clk);
    int_evt_a <= 8'hFF;
    int_evt_b <= 8'hFF;
    rd(`PIPS_REG_ISA);
    check("isa disabled", q, 16'h0000);
    @(posedge sys_clk);
    int_evt_a <= 8'h00;
    int_evt_b <= 8'h00;
    wr(5'h05, 16'hFFFF);
    rd(5'h05);
    check("unmapped", q, 16'h0000);
  endtask : t_reset
  ////////////////////
  // pin assertion, status, clear on read, polarity and master enable
  task automatic t_irq;
    wr(`PIPS_REG_PSC, 16'h0003);
    wr(`PIPS_REG_ISA, 16'h0005);
    rd(`PIPS_REG_PSC);
    check("psc", q, 16'h0003);
    @(posedge sys_clk);
    int_evt_a <= 8'h03;
    @(negedge sys_clk);
    check("pin async", 16'(pin_o), 16'h0000);
    check("pin_oe", 16'(pin_oe), 16'h0001);
    @(posedge sys_clk);
    int_evt_a <= 8'h00;
    repeat (3) @(negedge sys_clk);
    check("pin held", 16'(pin_o), 16'h0000);
    rd(`PIPS_REG_ISA);
    check("isa status", q, 16'h0105);
    check("pin released", 16'(pin_o), 16'h0001);
    rd(`PIPS_REG_ISA);
    check("isa cleared", q, 16'h0005);
    wr(`PIPS_REG_ISB, 16'h0080);
    @(posedge sys_clk);
    int_evt_b <= 8'h80;
    @(posedge sys_clk);
    int_evt_b <= 8'h00;
    wr(`PIPS_REG_PSC, 16'h0007);
    check("pin active high", 16'(pin_o), 16'h0001);
    rd(`PIPS_REG_ISB);
    check("isb status", q, 16'h8080);
    check("pin idle low", 16'(pin_o), 16'h0000);
    wr(`PIPS_REG_PSC, 16'h0005);
    @(posedge sys_clk);
    int_evt_a <= 8'h01;
    @(negedge sys_clk);
    check("pin masked", 16'(pin_o), 16'h0000);
    @(posedge sys_clk);
    int_evt_a <= 8'h00;
  endtask : t_irq
  ////////////////////
  // power-down by pin and bit, select decode, gating, wake-up
  task automatic t_power;
    pips_pmode_t exp_m [4];
    exp_m = '{PM_ACTIVE, PM_PWRDN, PM_LP_ACT, PM_LP_PAS};
    wr(`PIPS_REG_PSC, 16'h0000);
    @(posedge sys_clk);
    pin_ext_low <= 1'b1;
    repeat (5) @(negedge sys_clk);
    check("pin powerdown", 16'(pwr_mode), 16'(PM_PWRDN));
    check("core down", 16'(core_pwr_dn), 16'h0001);
    rd(`PIPS_REG_ISB);
    check("access in powerdown", q, 16'h0080);
    wr(`PIPS_REG_ISA, 16'h0006);
    rd(`PIPS_REG_ISA);
    // status bit 0 still pending from the masked event of the interrupt scenario
    check("write in powerdown", q, 16'h0106);
    @(posedge sys_clk);
    pin_ext_low <= 1'b0;
    repeat (5) @(negedge sys_clk);
    check("pin wake", 16'(pwr_mode), 16'(PM_ACTIVE));
    check("core up", 16'(core_pwr_dn), 16'h0000);
    wr(`PIPS_REG_BASIC, 16'h0800);
    check("bit11 powerdown", 16'(pwr_mode), 16'(PM_PWRDN));
    wr(`PIPS_REG_BASIC, 16'h8800);
    rd(`PIPS_REG_BASIC);
    check("soft reset", q, 16'h0000);
    for (int s = 0; s < 4; s++) begin
      wr(`PIPS_REG_PSC, 16'h4000 | 16'(s << 12));
      check("select", 16'(pwr_mode), 16'(exp_m[s]));
      wr(`PIPS_REG_PSC, 16'h4000);
      check("select cleared", 16'(pwr_mode), 16'(PM_ACTIVE));
      wr(`PIPS_REG_PSC, 16'(s << 12));
      check("select gated", 16'(pwr_mode), 16'(PM_ACTIVE));
    end
    wr(`PIPS_REG_PSC, 16'h0001);
    @(posedge sys_clk);
    pin_ext_low <= 1'b1;
    repeat (5) @(negedge sys_clk);
    check("pin as output", 16'(pwr_mode), 16'(PM_ACTIVE));
    @(posedge sys_clk);
    pin_ext_low <= 1'b0;
  endtask : t_power
  ////////////////////
  // hang guard
  initial begin
    repeat (60000) @(posedge sys_clk);
    num_errors++;
    results();
  end
  initial begin
    rst = 1'b1;
    int_evt_a = 8'h00;
    int_evt_b = 8'h00;
    pin_ext_low = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(negedge sys_clk);
    t_reset();
    t_irq();
    t_power();
    results();
  end
endmodule : phy_interrupt_power_save_ctrl_tb
`default_nettype wire

// ---- sim/pips_host.sv ----
// management host model: preamble, start, opcode, address and data frames on mdc
`timescale 1ns/1ns
`default_nettype none
module pips_host #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // clock
  input wire logic sys_clk,
  // management pins
  output logic mdc,
  output logic h_oe,
  output logic h_o,
  input wire logic mdio_line
);
  // half period above the 4-clock minimum, leaves room for the 2-flop sync
  localparam int HALF = 5;
  // mdc stands still low outside frames
  initial begin
    mdc = 1'b0;
    h_oe = 1'b0;
    h_o = 1'b1;
  end
  ////////////////////
  // one bit: change the line while mdc is low, sample just before the rise
  task automatic bit_io(input logic drv, input logic b, output logic v);
    @(posedge sys_clk);
    mdc <= 1'b0;
    h_oe <= drv;
    h_o <= b;
    repeat (HALF - 1) @(posedge sys_clk);
    @(negedge sys_clk);
    v = mdio_line;
    @(posedge sys_clk);
    mdc <= 1'b1;
    repeat (HALF) @(posedge sys_clk);
  endtask : bit_io
  ////////////////////
  // whole frame: fresh preamble each time, host releases the line on reads
  task automatic frame(input logic rd, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] q);
    logic [13:0] hdr;
    logic v;
    hdr = {2'b01, (rd ? 2'b10 : 2'b01), PHY_ADDR, ra};
    q = 16'h0000;
    for (int i = 0; i < 32; i++) bit_io(1'b1, 1'b1, v);
    for (int i = 13; i >= 0; i--) bit_io(1'b1, hdr[i], v);
    bit_io(!rd, 1'b1, v);
    bit_io(!rd, 1'b0, v);
    for (int i = 15; i >= 0; i--) begin
      bit_io(!rd, wd[i], v);
      q[i] = v;
    end
    // park: line back to its pull-up, leave time for the register update
    @(posedge sys_clk);
    mdc <= 1'b0;
    h_oe <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask : frame
endmodule : pips_host
`default_nettype wire
